// ---- cmf_top.v ----
// Purpose: comparator control: masking, fault routing, write protection
// Assumes: CMP_OUT comes from the analog core, asynchronous to CLK
// Notes: read data appear the cycle after the read strobe
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "cmf_consts.vh"
module cmf_top (
    input wire CLK,
    input wire RST_N,
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    input wire CMP_OUT,
    output wire CMP_ENABLE,
    output wire BIAS_CURRENT_SELECT,
    output wire FAULT_OUT
);
    reg [31:0] comparator_mode_reg_q;
    reg [31:0] analog_control_reg_q;
    reg write_lock_enable_q;
    reg write_violation_flag_q;
    reg [7:0] violation_source_q;
    reg sync1_q, sync2_q, prev_q, edge_q;
    wire hit_mode, hit_acr, hit_lock, protected_wr, wr_ok, masking, cmp_val, inv;
    // ------------------------------
    // address decode
    // ------------------------------
    function is_addr;
        input [7:0] a;
        input [7:0] ofs;
        begin
            is_addr = (a == ofs);
        end
    endfunction
    assign hit_mode = is_addr(ADDR, `CMF_OFS_MODE);
    assign hit_acr = is_addr(ADDR, `CMF_OFS_ACR);
    assign hit_lock = is_addr(ADDR, `CMF_OFS_LOCK_MODE);
    // RULE_11 protected set only
    assign protected_wr = WR & (hit_mode | hit_acr);
    // RULE_08 lock blocks writes
    assign wr_ok = protected_wr & ~write_lock_enable_q;
    // ------------------------------
    // configuration registers
    // ------------------------------
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            comparator_mode_reg_q <= `CMF_MODE_RESET;
            analog_control_reg_q <= `CMF_ACR_RESET;
            write_lock_enable_q <= 1'b0;
        end else begin
            if (wr_ok && hit_mode) begin
                comparator_mode_reg_q <= WDATA;
            end
            if (wr_ok && hit_acr) begin
                analog_control_reg_q <= WDATA;
            end
            if (WR && hit_lock && WDATA[31:8] == `CMF_LOCK_KEY) begin
                write_lock_enable_q <= WDATA[`CMF_LOCK_EN_BIT];
            end
        end
    end
    // ------------------------------
    // violation tracking
    // ------------------------------
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            write_violation_flag_q <= 1'b0;
            violation_source_q <= 8'h00;
        end else if (protected_wr && write_lock_enable_q) begin
            // RULE_09 flag and source, set beats clear
            write_violation_flag_q <= 1'b1;
            violation_source_q <= ADDR;
        end else if (RD && is_addr(ADDR, `CMF_OFS_LOCK_STAT)) begin
            // RULE_10 clear on status read
            write_violation_flag_q <= 1'b0;
        end
    end
    // ------------------------------
    // masking period
    // ------------------------------
    // RULE_02 any accepted mode or analog write starts it; lock register writes do not
    cmf_mask_timer u_mask (
        .clk(CLK),
        .rst_n(RST_N),
        .start(wr_ok),
        .bias_sel(wr_ok && hit_acr ? WDATA[`CMF_ACR_BIAS_BIT]
            : analog_control_reg_q[`CMF_ACR_BIAS_BIT]),
        .masking(masking)
    );
    // ------------------------------
    // comparator resync and event
    // ------------------------------
    assign inv = comparator_mode_reg_q[`CMF_MODE_INV_BIT];
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            sync1_q <= CMP_OUT;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            if (sync2_q != prev_q && !masking) begin
                edge_q <= 1'b1;
            end else if (RD && is_addr(ADDR, `CMF_OFS_ISR)) begin
                edge_q <= 1'b0;
            end
        end
    end
    assign cmp_val = sync2_q ^ inv;
    // RULE_06 fault mode output
    // RULE_07 combinational or resync
    assign FAULT_OUT = comparator_mode_reg_q[`CMF_MODE_FAULT_EN_BIT] &
        (comparator_mode_reg_q[`CMF_MODE_FAULT_SRC_BIT] ? cmp_val : (CMP_OUT ^ inv));
    assign CMP_ENABLE = comparator_mode_reg_q[`CMF_MODE_EN_BIT];
    assign BIAS_CURRENT_SELECT = analog_control_reg_q[`CMF_ACR_BIAS_BIT];
    // ------------------------------
    // read port
    // ------------------------------
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            if (hit_mode) begin
                RDATA <= comparator_mode_reg_q;
            end else if (hit_acr) begin
                RDATA <= analog_control_reg_q;
            end else if (is_addr(ADDR, `CMF_OFS_ISR)) begin
                // RULE_05 sign bit while masking
                RDATA <= {masking, 29'h0, cmp_val, edge_q};
            end else if (hit_lock) begin
                RDATA <= {31'h0, write_lock_enable_q};
            end else if (is_addr(ADDR, `CMF_OFS_LOCK_STAT)) begin
                RDATA <= {16'h0, violation_source_q, 7'h0, write_violation_flag_q};
            end else begin
                RDATA <= 32'h0000_0000;
            end
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end
endmodule // cmf_top

// ---- cmf_consts.vh ----
// Purpose: constants for the comparator mask and fault control block
// Assumes: 32-bit register port, 125 MHz peripheral clock
// Notes: offsets are word-aligned byte addresses
// Summary of operation
// RULE_01: output invalid after settings change, bias-timed
// RULE_02: mode or analog write starts masking
// RULE_03: bias select 0 masks 8 clocks
// RULE_04: bias select 1 masks 128 clocks
// RULE_05: status bit 31 set while masking
// RULE_06: fault mode forwards match events to fault
// RULE_07: fault source combinational or resynchronized
// RULE_08: lock enable blocks protected register writes
// RULE_09: locked write sets flag, records source
// RULE_10: reading lock status clears violation flag
// RULE_11: only mode and analog registers protected
// RULE_12: write during masking restarts count
`ifndef CMF_CONSTS_VH
`define CMF_CONSTS_VH
// register offsets
`define CMF_OFS_MODE 8'h04
`define CMF_OFS_ISR 8'h30
`define CMF_OFS_ACR 8'h94
`define CMF_OFS_LOCK_MODE 8'hE4
`define CMF_OFS_LOCK_STAT 8'hE8
// mode register fields
`define CMF_MODE_EN_BIT 8
`define CMF_MODE_INV_BIT 12
`define CMF_MODE_FAULT_EN_BIT 13
`define CMF_MODE_FAULT_SRC_BIT 14
`define CMF_MODE_RESET 32'h0000_0000
// analog control fields
`define CMF_ACR_BIAS_BIT 0
`define CMF_ACR_RESET 32'h0000_0000
// status and lock fields
`define CMF_ISR_MASK_BIT 31
`define CMF_ISR_OUT_BIT 1
`define CMF_ISR_EDGE_BIT 0
`define CMF_LOCK_EN_BIT 0
`define CMF_LOCK_KEY 24'hA1C3F0
`define CMF_VIOL_SRC_LSB 8
// masking lengths in clock periods
`define CMF_MASK_SHORT 8'h08
`define CMF_MASK_LONG 8'h80
`endif

// ---- cmf_mask_timer.v ----
// Purpose: masking period counter
// Assumes: start is a one-cycle pulse
// Notes: a start during a running period restarts it
`timescale 1ns/1ps
`include "cmf_consts.vh"
module cmf_mask_timer (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire bias_sel,
    output wire masking
);
    reg [7:0] cnt_q;
    // ------------------------------
    // countdown
    // ------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (start) begin
            // RULE_12 restart with new bias
            // RULE_03 RULE_04 bias length
            cnt_q <= bias_sel ? `CMF_MASK_LONG : `CMF_MASK_SHORT;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    // RULE_01 output invalid window
    assign masking = (cnt_q != 8'h00);
endmodule // cmf_mask_timer

// ---- cmf_cmp_core.sv ----
// Purpose: stand-in for the analog comparator core
// Assumes: the bench sets the compared level
// Notes: a disabled core gives a level that wanders each clock
`timescale 1ns/1ps
module cmf_cmp_core (
    input wire clk,
    input wire enable,
    input wire level,
    output wire cmp_out
);
    reg flip_q = 1'b0;
    // output of a disabled core is not to be trusted
    always @(posedge clk) flip_q <= ~flip_q;
    assign #2 cmp_out = enable ? level : flip_q;
endmodule // cmf_cmp_core

// ---- cmf_top_asserts.sv ----
// Purpose: port checks for the comparator control block
// Assumes: lock, fault bits and mask time shadowed from writes
// Notes: the mask shadow follows the written bias on an analog write, else the bias in force
`timescale 1ns/1ps
`include "cmf_consts.vh"
module cmf_top_asserts (
    input wire CLK,
    input wire RST_N,
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    input wire CMP_OUT,
    input wire CMP_ENABLE,
    input wire BIAS_CURRENT_SELECT,
    input wire FAULT_OUT
);
    reg lk_q;
    reg [1:0] md_q;
    reg [7:0] cnt_q;
    wire pw = WR && (ADDR == `CMF_OFS_MODE || ADDR == `CMF_OFS_ACR);
    wire rs = RD && ADDR == `CMF_OFS_LOCK_STAT;
    wire ri = RD && ADDR == `CMF_OFS_ISR;
    // shadow of lock, fault bits and mask time
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            lk_q <= 1'b0;
            md_q <= 2'h0;
            cnt_q <= 8'h00;
        end else begin
            if (WR && ADDR == `CMF_OFS_LOCK_MODE && WDATA[31:8] == `CMF_LOCK_KEY)
                lk_q <= WDATA[0];
            if (pw && !lk_q && ADDR == `CMF_OFS_MODE)
                md_q <= WDATA[14:13];
            if (pw && !lk_q && (ADDR == `CMF_OFS_ACR ? WDATA[0] : BIAS_CURRENT_SELECT))
                cnt_q <= `CMF_MASK_LONG;
            else if (pw && !lk_q)
                cnt_q <= `CMF_MASK_SHORT;
            else if (cnt_q != 8'h00)
                cnt_q <= cnt_q - 8'h01;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_ok; pw && !lk_q; endsequence
    sequence s_bad; pw && lk_q; endsequence
    sequence s_short; s_ok ##0 ADDR == `CMF_OFS_ACR && !WDATA[0]; endsequence
    lock_block_a: assert property (s_bad ##0 ADDR == `CMF_OFS_ACR
        |=> $stable(BIAS_CURRENT_SELECT))
        else $error("locked write changed bias");
    viol_flag_a: assert property (s_bad ##1 (!WR && !rs) ##1 rs
        |=> RDATA[0] && RDATA[15:8] == $past(ADDR, 3))
        else $error("violation not recorded");
    viol_clear_a: assert property (rs ##1 !WR ##1 rs |=> !RDATA[0])
        else $error("violation flag not cleared");
    mask_flag_a: assert property (s_ok ##2 ri |=> RDATA[31])
        else $error("masking not reported");
    mask_on_a: assert property (s_short ##8 ri |=> RDATA[31])
        else $error("short mask too short");
    mask_off_a: assert property (s_short ##1 !pw [*8] ##1 ri |=> !RDATA[31])
        else $error("short mask too long");
    mask_len_a: assert property (ri |=> RDATA[31] == ($past(cnt_q) != 8'h00))
        else $error("mask length wrong");
    comb_path_a: assert property (CMP_ENABLE && md_q == 2'b01 && cnt_q == 8'h00
        && $changed(CMP_OUT) |-> $changed(FAULT_OUT))
        else $error("fault path not direct");
    resync_lag_a: assert property (CMP_ENABLE && md_q == 2'b11 && cnt_q == 8'h00
        && $past(CMP_OUT, 2) == $past(CMP_OUT, 3) |-> $stable(FAULT_OUT))
        else $error("fault path not resynchronized");
endmodule // cmf_top_asserts
bind cmf_top cmf_top_asserts u_chk (.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .CMP_OUT,
    .CMP_ENABLE, .BIAS_CURRENT_SELECT, .FAULT_OUT);

// ---- comparator_mask_fault_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the comparator control block
// Assumes: register port with read data one cycle after the strobe
// Notes: masking, write lock and fault routing scenarios
`timescale 1ns/1ps
`include "cmf_consts.vh"
module comparator_mask_fault_ctrl_tb_top;
    logic CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, lvl = 1'b0, f;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    wire [31:0] RDATA;
    wire CMP_OUT, CMP_ENABLE, BIAS_CURRENT_SELECT, FAULT_OUT;
    int num_errors = 0, checked = 0, cyc = 0;
    always #4 CLK = ~CLK;
    cmf_top dut (.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .CMP_OUT, .CMP_ENABLE,
        .BIAS_CURRENT_SELECT, .FAULT_OUT);
    cmf_cmp_core core (.clk(CLK), .enable(CMP_ENABLE), .level(lvl), .cmp_out(CMP_OUT));
    task chk(input logic ok);
        checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("FAIL %0t value mismatch", $time);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge CLK); ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CLK); WR <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] m, input [31:0] e);
        @(posedge CLK); ADDR <= a; RD <= 1'b1;
        @(posedge CLK); RD <= 1'b0;
        #1 chk((RDATA & m) === e);
    endtask
    task t_mask;
        wr(`CMF_OFS_ACR, 32'h0); repeat (6) @(posedge CLK);
        rd(`CMF_OFS_ISR, 32'h80000000, 32'h80000000);
        wr(`CMF_OFS_ACR, 32'h0); repeat (7) @(posedge CLK);
        rd(`CMF_OFS_ISR, 32'h80000000, 32'h0);
        wr(`CMF_OFS_ACR, 32'h1); #1 chk(BIAS_CURRENT_SELECT === 1'b1);
        repeat (60) @(posedge CLK);
        wr(`CMF_OFS_MODE, 32'h0); repeat (126) @(posedge CLK);
        rd(`CMF_OFS_ISR, 32'h80000000, 32'h80000000);
        rd(`CMF_OFS_ISR, 32'h80000000, 32'h0);
        wr(`CMF_OFS_ACR, 32'h0); wr(`CMF_OFS_ACR, 32'h1); repeat (20) @(posedge CLK);
        rd(`CMF_OFS_ISR, 32'h80000000, 32'h80000000);
    endtask
    task t_lock;
        wr(`CMF_OFS_LOCK_MODE, {`CMF_LOCK_KEY, 8'h01});
        wr(`CMF_OFS_ACR, 32'h0); #1 chk(BIAS_CURRENT_SELECT === 1'b1);
        rd(`CMF_OFS_LOCK_STAT, 32'h0000FF01, 32'h00009401);
        rd(`CMF_OFS_LOCK_STAT, 32'h1, 32'h0);
        wr(`CMF_OFS_LOCK_MODE, 32'h0); wr(`CMF_OFS_MODE, 32'h0);
        rd(`CMF_OFS_LOCK_STAT, 32'h0000FF01, 32'h00000401);
        wr(`CMF_OFS_LOCK_MODE, {`CMF_LOCK_KEY, 8'h00}); wr(`CMF_OFS_ACR, 32'h0);
        #1 chk(BIAS_CURRENT_SELECT === 1'b0);
    endtask
    task t_fault;
        for (int s = 0; s < 2; s++) begin
            wr(`CMF_OFS_MODE, {17'h0, s[0], 1'b1, s[0], 12'h100});
            rd(`CMF_OFS_ISR, 32'h80000000, 32'h80000000);
            repeat (10) @(posedge CLK);
            f = FAULT_OUT;
            lvl <= ~lvl;
            @(posedge CLK); #1 chk((FAULT_OUT !== f) === (s == 0));
            repeat (3) @(posedge CLK); #1 chk(FAULT_OUT !== f);
            rd(`CMF_OFS_ISR, 32'h80000003, 32'h3);
            rd(`CMF_OFS_ISR, 32'h1, 32'h0);
        end
    endtask
    // mid-run reset clears outputs and state
    task t_reset;
        wr(`CMF_OFS_MODE, 32'h100); rd(`CMF_OFS_MODE, 32'hFFFFFFFF, 32'h100);
        chk(CMP_ENABLE === 1'b1);
        @(posedge CLK); RST_N <= 1'b0;
        repeat (2) @(posedge CLK); RST_N <= 1'b1;
        #1 chk({CMP_ENABLE, BIAS_CURRENT_SELECT, FAULT_OUT, RDATA} === 35'h0);
        rd(`CMF_OFS_ISR, 32'h80000000, 32'h0);
        rd(`CMF_OFS_LOCK_STAT, 32'h0000FF01, 32'h0);
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        t_mask; t_lock; t_fault; t_reset;
        report_and_stop;
    end
    // hang guard
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            report_and_stop;
        end
    end
endmodule // comparator_mask_fault_ctrl_tb_top
